/* pwk_regs.vh */
// Register map, field positions, reset values and timing counts of the
// periodic wakeup and reset status block.
// Assumes a 200 MHz core clock and a 1 kHz low-frequency oscillator.
`ifndef PWK_REGS_VH
`define PWK_REGS_VH

// ==========================================================================
// Register offsets
`define PWK_ADDR_W 16
`define PWK_RESET_SOURCE_STATUS 16'h1800
`define PWK_SYSTEM_OPTIONS_ONE 16'h1802
`define PWK_PERIODIC_TIMER_STATUS_CONTROL 16'h1808
`define PWK_ANALOG_CTRL 16'h180c

// ==========================================================================
// Periodic timer status/control fields
`define PWK_TICK_FLAG_BIT 7
`define PWK_TICK_ACK_BIT 6
`define PWK_TICK_CLKSEL_BIT 5
`define PWK_TICK_IRQEN_BIT 4
`define PWK_PERIOD_MSB 2
`define PWK_PERIOD_LSB 0
`define PWK_PTSC_RESET 8'h00

// ==========================================================================
// System options fields (only the temperature restart bits live here)
`define PWK_TEMP_EN_BIT 3
`define PWK_TEMP_POL_BIT 2
`define PWK_SOPT_RESET 8'h00

// ==========================================================================
// Reset source fields and values
`define PWK_SRC_POWER_ON_BIT 7
`define PWK_SRC_LOW_VOLT_BIT 1
`define PWK_SRC_POWER_ON_VALUE 8'h82
`define PWK_SRC_OTHER_MASK 8'h7c

// ==========================================================================
// Timing
`define PWK_CLK_HZ 200000000
`define PWK_SLOW_TICK_MS 1
`define PWK_SLOW_TICK_CYCLES (`PWK_CLK_HZ / 1000 * `PWK_SLOW_TICK_MS)
`define PWK_FAST_DIV 5

`endif

/* pwk_prescaler.v */
// Millisecond prescaler and period counter of the periodic wakeup timer.
// Assumes the slow tick input is already synchronised to clk.
`timescale 1ns/1ps

module pwk_prescaler (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Control
   input wire [2:0] tick_period_select,
   input wire tick_advance,
   // Result
   output reg period_done
);

   reg [7:0] count;

   // Period select 001 -> 2 ms ... 111 -> 128 ms
   function [7:0] period_limit;
      input [2:0] sel;
      begin
         period_limit = (8'h01 << sel) - 8'h01;
      end
   endfunction

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 8'h00;
         period_done <= 1'b0;
      end else if (tick_period_select == 3'h0) begin
         // Timer off: counter parked
         count <= 8'h00;
         period_done <= 1'b0;
      end else if (tick_advance) begin
         if (count >= period_limit(tick_period_select)) begin
            count <= 8'h00;
            period_done <= 1'b1;
         end else begin
            count <= count + 8'h01;
            period_done <= 1'b0;
         end
      end else begin
         period_done <= 1'b0;
      end
   end

endmodule

/* pwk_periodic_wakeup.v */
// Periodic wakeup timer with its status/control register, temperature
// restart arming, and the reset source status register.
// Assumes the slow oscillator, power mode and reset cause inputs come from
// other domains or pins; they are synchronised here before use.
// How it works
// - Clock select 0 counts slow oscillator ticks, 1 counts divided core clock in run.
// - Slow oscillator enable output is tied on; software cannot stop it.
// - Tick raises an interrupt request in run or light stop mode, and a wakeup request in light stop mode with run low.
// - Tick sets the flag while in run or light stop mode.
// - Flag ignores zero writes; reset and deepest stop exit clear it.
// - Writing one to acknowledge clears the flag; acknowledge reads as zero.
// - Interrupt enable gates the request; reset clears it.
// - Period select 001..111 gives 2 to 128 ms; 000 is off; reset clears.
// - Deepest stop wake asks for the reset vector, overriding timer vector.
// - Temperature restart armed by enable bit; polarity picks cold or hot wake.
// - Return into normal range wakes; deepest stop exit then resets device.
// - Temperature sensor enable follows the converter enable.
// - Reset source register holds seven read-only cause flags at 0x1800.
// - Debug forced reset leaves every reset source flag clear.
// - Any write to reset source address restarts watchdog, contents unchanged.
// - Power-on or low-voltage reset reads bits 7 and 1 set, rest clear.
// - Other resets set each flag whose source was active, clear the others.
// - Bit 0 of reset source reads as zero always.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "pwk_regs.vh"

module pwk_periodic_wakeup (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Register port
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   // Oscillator and power mode (asynchronous)
   input wire low_freq_osc,
   input wire run_mode,
   input wire light_stop_mode,
   input wire deepest_stop_mode,
   output wire low_freq_osc_enable,
   // Reset cause capture (asynchronous levels, sampled at reset release)
   input wire power_on_cause,
   input wire low_voltage_cause,
   input wire debug_force_reset,
   input wire [4:0] other_reset_causes,
   // Temperature restart
   input wire temp_too_cold,
   input wire temp_too_hot,
   input wire analog_converter_enable,
   output wire temp_sensor_enable,
   output wire temp_restart_armed,
   output reg temp_restart_wakeup,
   // Outputs to the core
   output wire periodic_irq,
   output wire periodic_wakeup,
   output wire use_reset_vector,
   output reg watchdog_restart
);

   // ======================================================================
   // Input synchronisers
   localparam SYNC_W = 14;
   reg [SYNC_W-1:0] sync_a;
   reg [SYNC_W-1:0] sync_b;
   wire [SYNC_W-1:0] raw_in = {temp_too_hot, temp_too_cold, other_reset_causes,
      debug_force_reset, low_voltage_cause, power_on_cause, deepest_stop_mode,
      light_stop_mode, run_mode, low_freq_osc};

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= {SYNC_W{1'b0}};
         sync_b <= {SYNC_W{1'b0}};
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   wire s_osc = sync_b[0];
   wire s_run = sync_b[1];
   wire s_light = sync_b[2];
   wire s_deep = sync_b[3];
   wire s_por = sync_b[4];
   wire s_lvd = sync_b[5];
   wire s_dbg = sync_b[6];
   wire [4:0] s_other = sync_b[11:7];
   wire s_cold = sync_b[12];
   wire s_hot = sync_b[13];

   // ======================================================================
   // Control registers
   reg tick_flag;
   reg tick_clock_select;
   reg tick_irq_enable;
   reg [2:0] tick_period_select;
   reg temp_restart_enable;
   reg temp_restart_polarity;
   reg [7:0] reset_source_status;
   reg [1:0] cap_state;
   reg osc_prev;
   reg deep_prev;
   reg [2:0] fast_div;
   reg out_of_range;
   // Reload value of the fast divider, cut to the divider's width
   localparam [31:0] FAST_LOAD = `PWK_FAST_DIV - 1;

   wire wr_ptsc = reg_write && (reg_addr == `PWK_PERIODIC_TIMER_STATUS_CONTROL);
   wire wr_sopt = reg_write && (reg_addr == `PWK_SYSTEM_OPTIONS_ONE);
   wire wr_src = reg_write && (reg_addr == `PWK_RESET_SOURCE_STATUS);

   // ======================================================================
   // Tick source: slow oscillator edge, or divided core clock in run only
   wire slow_edge = s_osc && !osc_prev;
   wire fast_edge = (fast_div == 3'h0) && s_run;
   wire tick_advance = tick_clock_select ? fast_edge : slow_edge;
   wire period_done;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_prev <= 1'b0;
         fast_div <= 3'h0;
         deep_prev <= 1'b0;
      end else begin
         osc_prev <= s_osc;
         deep_prev <= s_deep;
         // Without a stand-in for the fast oscillator, the core clock
         // divided down keeps the count rate bounded
         if (fast_div == 3'h0)
            fast_div <= FAST_LOAD[2:0];
         else
            fast_div <= fast_div - 3'h1;
      end
   end

   pwk_prescaler u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .tick_period_select(tick_period_select),
      .tick_advance(tick_advance),
      .period_done(period_done)
   );

   // Oscillator cannot be switched off from software
   assign low_freq_osc_enable = 1'b1;

   // ======================================================================
   // Flag and control writes
   wire deep_exit = deep_prev && !s_deep;
   wire flag_set = period_done && (s_run || s_light);
   wire flag_ack = wr_ptsc && reg_wdata[`PWK_TICK_ACK_BIT];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_flag <= 1'b0;
         tick_clock_select <= 1'b0;
         tick_irq_enable <= 1'b0;
         tick_period_select <= 3'h0;
         temp_restart_enable <= 1'b0;
         temp_restart_polarity <= 1'b0;
      end else begin
         // A tick in the same cycle as the acknowledge wins
         if (flag_set)
            tick_flag <= 1'b1;
         else if (flag_ack || deep_exit)
            tick_flag <= 1'b0;
         if (wr_ptsc) begin
            tick_clock_select <= reg_wdata[`PWK_TICK_CLKSEL_BIT];
            tick_irq_enable <= reg_wdata[`PWK_TICK_IRQEN_BIT];
            tick_period_select <= reg_wdata[`PWK_PERIOD_MSB:`PWK_PERIOD_LSB];
         end
         if (wr_sopt) begin
            temp_restart_enable <= reg_wdata[`PWK_TEMP_EN_BIT];
            temp_restart_polarity <= reg_wdata[`PWK_TEMP_POL_BIT];
         end
      end
   end

   assign periodic_irq = tick_flag && tick_irq_enable;
   // Wakeup from low-power modes is the same gated request
   assign periodic_wakeup = periodic_irq && !s_run;
   // Deepest stop is left through reset, so the reset vector wins
   assign use_reset_vector = s_deep && (periodic_wakeup || temp_restart_wakeup);

   // ======================================================================
   // Temperature restart
   assign temp_sensor_enable = analog_converter_enable;
   assign temp_restart_armed = temp_restart_enable;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_of_range <= 1'b0;
         temp_restart_wakeup <= 1'b0;
      end else begin
         // Polarity 1 watches the hot side, 0 the cold side
         out_of_range <= temp_restart_polarity ? s_hot : s_cold;
         // Pulse when the temperature comes back into range
         temp_restart_wakeup <= temp_restart_enable && out_of_range
            && !(temp_restart_polarity ? s_hot : s_cold);
      end
   end

   // ======================================================================
   // Reset source capture: causes are sampled after release, never under reset
   localparam CAP_WAIT = 2'h0;
   localparam CAP_TAKE = 2'h1;
   localparam CAP_DONE = 2'h2;
   localparam CAP_FILL = 2'h3;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_state <= CAP_WAIT;
         reset_source_status <= 8'h00;
      end else begin
         case (cap_state)
            CAP_WAIT: begin
               // Both synchroniser stages must hold the causes before sampling
               cap_state <= CAP_FILL;
            end
            CAP_FILL: begin
               cap_state <= CAP_TAKE;
            end
            CAP_TAKE: begin
               cap_state <= CAP_DONE;
               if (s_dbg)
                  reset_source_status <= 8'h00;
               else if (s_por || s_lvd)
                  reset_source_status <= `PWK_SRC_POWER_ON_VALUE;
               else
                  reset_source_status <= {1'b0, s_other, 2'b00}
                     & `PWK_SRC_OTHER_MASK;
            end
            CAP_DONE: begin
               cap_state <= CAP_DONE;
            end
            default: begin
               cap_state <= CAP_DONE;
            end
         endcase
      end
   end

   // ======================================================================
   // Read port and watchdog restart
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         watchdog_restart <= 1'b0;
      end else begin
         // Writes to the status address never touch its contents
         watchdog_restart <= wr_src;
         if (reg_read) begin
            case (reg_addr)
               `PWK_RESET_SOURCE_STATUS:
                  reg_rdata <= {reset_source_status[7:1], 1'b0};
               `PWK_PERIODIC_TIMER_STATUS_CONTROL:
                  reg_rdata <= {tick_flag, 1'b0, tick_clock_select, tick_irq_enable,
                     1'b0, tick_period_select};
               `PWK_SYSTEM_OPTIONS_ONE:
                  reg_rdata <= {4'h0, temp_restart_enable, temp_restart_polarity, 2'b00};
               default:
                  reg_rdata <= 8'h00;
            endcase
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

endmodule

/* pwk_periodic_wakeup_asserts.sv */
// Checker for the periodic wakeup block, seeing only its top-level ports.
// Assumes the register map defines of pwk_regs.vh and a single clock.
`timescale 1ns/1ps
`include "pwk_regs.vh"

module pwk_periodic_wakeup_chk (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Register port
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_rdata,
   // Status outputs and the converter enable input
   input wire low_freq_osc_enable,
   input wire analog_converter_enable,
   input wire temp_sensor_enable,
   input wire temp_restart_armed,
   input wire temp_restart_wakeup,
   input wire periodic_irq,
   input wire periodic_wakeup,
   input wire use_reset_vector,
   input wire watchdog_restart
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire ctl_hit = reg_addr == `PWK_PERIODIC_TIMER_STATUS_CONTROL;
   wire src_hit = reg_addr == `PWK_RESET_SOURCE_STATUS;

   // ====================
   // Assertions
   osc_always_on_a: assert property (low_freq_osc_enable)
      else $error("slow oscillator enable dropped");
   sensor_follows_adc_a: assert property (temp_sensor_enable == analog_converter_enable)
      else $error("sensor enable differs from converter enable");
   irq_enable_gate_a: assert property (reg_write && ctl_hit && !reg_wdata[4] |=> !periodic_irq)
      else $error("interrupt request with enable cleared");
   ack_reads_zero_a: assert property (reg_read && ctl_hit |=> !reg_rdata[6])
      else $error("acknowledge bit read as one");
   unused_bit_zero_a: assert property (reg_read && src_hit |=> !reg_rdata[0])
      else $error("reset source bit 0 read as one");
   watchdog_pulse_a: assert property (watchdog_restart == $past(reg_write && src_hit))
      else $error("watchdog restart pulse wrong");
   idle_rdata_zero_a: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data outside the answer cycle");
   wake_needs_irq_a: assert property (periodic_wakeup |-> periodic_irq)
      else $error("wakeup without interrupt request");
   vector_cause_a: assert property (use_reset_vector |-> periodic_wakeup || temp_restart_wakeup)
      else $error("reset vector without wakeup");
   temp_pulse_a: assert property (temp_restart_wakeup |-> temp_restart_armed ##1 !temp_restart_wakeup)
      else $error("temperature wakeup not a single armed pulse");
   armed_write_a: assert property (reg_write && reg_addr == `PWK_SYSTEM_OPTIONS_ONE
      |=> temp_restart_armed == $past(reg_wdata[3]))
      else $error("temperature restart arming not written");

   // ====================
   // Cover
   cover property (periodic_irq);
   cover property (temp_restart_wakeup);
   cover property (use_reset_vector);
endmodule

bind pwk_periodic_wakeup pwk_periodic_wakeup_chk u_chk (.clk, .rst_n, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .low_freq_osc_enable, .analog_converter_enable,
   .temp_sensor_enable, .temp_restart_armed, .temp_restart_wakeup, .periodic_irq,
   .periodic_wakeup, .use_reset_vector, .watchdog_restart);

/* pwk_periodic_wakeup_tb_top.sv */
// Self-checking testbench of the periodic wakeup block.
// Assumes the bound checker; the slow oscillator is sped up to 16 clocks.
`timescale 1ns/1ps
`include "pwk_regs.vh"

module pwk_periodic_wakeup_tb_top;
   localparam logic [15:0] a_ctl = `PWK_PERIODIC_TIMER_STATUS_CONTROL;
   localparam logic [15:0] a_src = `PWK_RESET_SOURCE_STATUS;
   localparam logic [15:0] a_opt = `PWK_SYSTEM_OPTIONS_ONE;
   logic clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, low_freq_osc = 0, run_mode = 1;
   logic light_stop_mode = 0, deepest_stop_mode = 0, power_on_cause = 1, low_voltage_cause = 0;
   logic debug_force_reset = 0, temp_too_cold = 0, temp_too_hot = 0, analog_converter_enable = 0;
   logic [15:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0;
   logic [4:0] other_reset_causes = 0, oc;
   wire [7:0] reg_rdata;
   wire low_freq_osc_enable, temp_sensor_enable, temp_restart_armed, temp_restart_wakeup;
   wire periodic_irq, periodic_wakeup, use_reset_vector, watchdog_restart;
   wire [2:0] ev = {temp_restart_wakeup, periodic_wakeup, periodic_irq};
   int n_mismatch = 0, n_checks = 0, t;
   logic [7:0] exp_q[$];
   logic [7:0] exp_r;
   logic rd_q = 0;

   pwk_periodic_wakeup dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .low_freq_osc, .run_mode, .light_stop_mode, .deepest_stop_mode,
      .low_freq_osc_enable, .power_on_cause, .low_voltage_cause, .debug_force_reset,
      .other_reset_causes, .temp_too_cold, .temp_too_hot, .analog_converter_enable,
      .temp_sensor_enable, .temp_restart_armed, .temp_restart_wakeup, .periodic_irq,
      .periodic_wakeup, .use_reset_vector, .watchdog_restart);

   always #2.5 clk = ~clk;
   // Fast stand-in for the 1 kHz source keeps the 128-tick period short
   always begin
      repeat (8) @(posedge clk);
      low_freq_osc <= ~low_freq_osc;
   end

   // ====================
   // Tasks
   task automatic chk(input logic [31:0] got, exp, input bit ok);
      n_checks++;
      if (!ok) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1;
      @(posedge clk);
      reg_write <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_read <= 1;
      @(posedge clk);
      reg_read <= 0;
      @(posedge clk);
   endtask
   task automatic rst(input logic po, lv, dbg, input logic [4:0] c);
      rst_n <= 0;
      power_on_cause <= po;
      low_voltage_cause <= lv;
      debug_force_reset <= dbg;
      other_reset_causes <= c;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      repeat (5) @(posedge clk);
   endtask
   task automatic await(input int s, input int lim);
      t = 0;
      while (t < lim && ev[s] !== 1'b1) begin
         @(posedge clk);
         t++;
      end
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_q) begin
         exp_r = exp_q.pop_front();
         chk(reg_rdata, exp_r, reg_rdata === exp_r);
      end
      rd_q <= reg_read;
   end

   // ====================
   // Scenarios
   initial begin
      void'($urandom(32'h2f37c8d5));
      rst(1, 0, 0, 0);
      rd(a_src, 8'h82);
      rd(a_ctl, 8'h00);
      rst(0, 1, 0, 0);
      rd(a_src, 8'h82);
      repeat (3) begin
         oc = 5'($urandom);
         rst(0, 0, 0, oc);
         rd(a_src, {1'b0, oc, 2'b00});
         wr(a_src, 8'($urandom));
         rd(a_src, {1'b0, oc, 2'b00});
      end
      rst(0, 0, 1, 5'h1f);
      rd(a_src, 8'h00);
      rd(16'h1804, 8'h00);
      for (int p = 1; p < 8; p++) begin
         wr(a_ctl, 8'h40);
         rd(a_ctl, 8'h00);
         wr(a_ctl, 8'h50 | 8'(p));
         await(0, 4200);
         chk(t, 16 << p, t >= (16 << p) - 20 && t <= (16 << p) + 10);
      end
      wr(a_ctl, 8'h40);
      wr(a_ctl, 8'h73);
      await(0, 200);
      chk(t, 40, t >= 34 && t <= 50);
      wr(a_ctl, 8'h40);
      run_mode <= 0;
      light_stop_mode <= 1;
      wr(a_ctl, 8'h51);
      await(1, 100);
      chk(periodic_wakeup, 1, periodic_wakeup === 1'b1);
      light_stop_mode <= 0;
      deepest_stop_mode <= 1;
      repeat (4) @(posedge clk);
      chk(use_reset_vector, 1, use_reset_vector === 1'b1);
      deepest_stop_mode <= 0;
      repeat (64) @(posedge clk);
      chk(periodic_irq, 0, periodic_irq === 1'b0);
      run_mode <= 1;
      wr(a_ctl, 8'h40);
      for (int k = 0; k < 3; k++) begin
         analog_converter_enable <= k[0];
         wr(a_opt, {4'h0, k < 2, k[0], 2'b00});
         rd(a_opt, {4'h0, k < 2, k[0], 2'b00});
         temp_too_cold <= 1;
         temp_too_hot <= 1;
         repeat (6) @(posedge clk);
         temp_too_cold <= 0;
         temp_too_hot <= 0;
         await(2, 20);
         chk(t, 20, (t < 20) == (k < 2));
      end
      repeat (4) @(posedge clk);
      conclude();
   end

   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end
endmodule
